// ---- etu_unit.sv ----
// exception dispatch, save and restore, timers and debug events
//
// What this block does
// RULE_01: every interrupt is critical or noncritical, each level separate.
// RULE_02: critical interrupts save pc and state in the critical pair.
// RULE_03: critical return restores the critical pair, normal return the other.
// RULE_04: an exception records its cause bits in the cause syndrome register.
// RULE_05: data-side faults capture the operand address in the fault register.
// RULE_06: the handler table base is any 64KB-aligned address from the prefix.
// RULE_07: critical input goes to 0x0100, aux unit unavailable to 0x0F20.
// RULE_08: countdown to 0x1000, fixed tick to 0x1010, watchdog to 0x1020.
// RULE_09: data TLB miss 0x1100, instruction TLB miss 0x1200, debug 0x2000.
// RULE_10: the countdown decrements once per time base tick.
// RULE_11: countdown timeout raises the countdown interrupt.
// RULE_12: fixed tick interrupt on a chosen time base bit transition.
// RULE_13: watchdog is a critical interrupt on a chosen bit transition.
// RULE_14: timer control steers the timers; timer status reports events.
// RULE_15: accesses are big-endian unless the page endian attribute is set.
// RULE_16: no global little-endian bit lives in machine state.
// RULE_17: address matches on fetch and data raise debug events and status.
// RULE_18: wait-enable enters wait; any interrupt clears it and resumes.
// RULE_19: vector is prefix upper sixteen bits joined to the offset.
// RULE_20: critical interrupts win over pending noncritical ones.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module etu_unit import etu_pkg::*; (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register bus
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // event sources
  input  wire logic        crit_in,
  input  wire logic        exc_itlb,
  input  wire logic        exc_dtlb,
  input  wire logic        exc_aux,
  input  wire logic        exc_store,
  input  wire logic [31:0] exc_daddr,
  input  wire logic [31:0] cur_pc,
  input  wire logic        ret_req,
  input  wire logic        cret_req,
  input  wire logic        iaddr_vld,
  input  wire logic [31:0] iaddr,
  input  wire logic        daddr_vld,
  input  wire logic [31:0] daddr,
  // memory access lane order
  input  wire logic [31:0] acc_wdata,
  input  wire logic        acc_le,
  output logic [31:0]      acc_data,
  // core control
  output logic             intr_take,
  output logic             intr_crit,
  output logic [31:0]      intr_vector,
  output logic             resume_vld,
  output logic [31:0]      resume_pc,
  output logic             wait_state
);
  typedef struct packed {
    logic [31:0] nsa;
    logic [31:0] nss;
    logic [31:0] csa;
    logic [31:0] css;
    logic [31:0] cause_syndrome_reg;
    logic [31:0] fda;
    logic [31:0] vpr;
    logic [31:0] timer_control_reg;
    logic [31:0] timer_status_reg;
    logic [31:0] machine_state_reg;
    logic [31:0] dca;
    logic [31:0] dcb;
    logic [31:0] dst;
    logic        p_itlb;
    logic        p_dtlb;
    logic        p_aux;
    logic        p_st;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    logic        take;
    logic        crit;
    logic [31:0] vec;
    logic        rvld;
    logic [31:0] rpc;
    logic [31:0] acc;
    etu_st_t     st;
  } etu_state_t;

  etu_state_t  q;
  etu_state_t  d;
  logic [31:0] tb_val;
  logic [31:0] pit_val;
  logic        pit_to;
  logic        fit_evt;
  logic        wdt_evt;
  logic        bus_wr;
  logic        crit_pend;
  logic        nc_pend;
  logic [15:0] off;

  function automatic logic is_mapped(input logic [11:0] a);
    return a == OFF_NSA || a == OFF_NSS || a == OFF_CSA ||
           a == OFF_CSS || a == OFF_CSR || a == OFF_FDA ||
           a == OFF_VPR || a == OFF_PIT || a == OFF_TCR ||
           a == OFF_TSR || a == OFF_MSR || a == OFF_DCA ||
           a == OFF_DCB || a == OFF_DST || a == OFF_TB;
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  assign bus_wr = psel && penable && q.rdy && pwrite;

  etu_timer u_timer (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .fit_sel   (q.timer_control_reg[TCR_FP+1:TCR_FP]),
    .wdt_sel   (q.timer_control_reg[TCR_WP+1:TCR_WP]),
    .pit_wr    (bus_wr && paddr == OFF_PIT),
    .pit_wdata (pwdata),
    .tb_val    (tb_val),
    .pit_val   (pit_val),
    .pit_to    (pit_to),
    .fit_evt   (fit_evt),
    .wdt_evt   (wdt_evt)
  );

  // pending levels: registered status plus the live critical input level
  always_comb begin
    crit_pend = (q.machine_state_reg[MSR_CE] &&
                 (crit_in || (q.timer_status_reg[TSR_WIS] && q.timer_control_reg[TCR_WIE]))) ||
                (q.machine_state_reg[MSR_DE] && q.dst[DBG_DAC:DBG_IAC] != 2'h0);
    nc_pend   = q.p_itlb || q.p_dtlb || q.p_aux ||
                (q.machine_state_reg[MSR_EE] &&
                 ((q.timer_status_reg[TSR_PIS] && q.timer_control_reg[TCR_PIE]) ||
                  (q.timer_status_reg[TSR_FIS] && q.timer_control_reg[TCR_FIE])));
  end

  always_comb begin
    d      = q;
    d.rdy  = 1'b0;
    d.err  = 1'b0;
    d.take = 1'b0;
    d.rvld = 1'b0;
    off    = VEC_CRIT;
    d.acc  = acc_le ? swap32(acc_wdata) : acc_wdata; // [RULE_15] [RULE_16]
    // setup phase: prepare the answer for a zero-wait access phase
    if (psel && !penable) begin
      d.rdy   = 1'b1;
      d.err   = !is_mapped(paddr);
      d.rdata = RST_ZERO;
      case (paddr)
        OFF_NSA: d.rdata = q.nsa;
        OFF_NSS: d.rdata = q.nss;
        OFF_CSA: d.rdata = q.csa;
        OFF_CSS: d.rdata = q.css;
        OFF_CSR: d.rdata = q.cause_syndrome_reg;
        OFF_FDA: d.rdata = q.fda;
        OFF_VPR: d.rdata = q.vpr;
        OFF_PIT: d.rdata = pit_val;
        OFF_TCR: d.rdata = q.timer_control_reg;
        OFF_TSR: d.rdata = q.timer_status_reg; // [RULE_14]
        OFF_MSR: d.rdata = q.machine_state_reg;
        OFF_DCA: d.rdata = q.dca;
        OFF_DCB: d.rdata = q.dcb;
        OFF_DST: d.rdata = q.dst;
        OFF_TB:  d.rdata = tb_val;
        default: d.rdata = RST_ZERO;
      endcase
    end
    if (bus_wr) begin
      case (paddr)
        OFF_NSA: d.nsa = pwdata;
        OFF_NSS: d.nss = pwdata;
        OFF_CSA: d.csa = pwdata;
        OFF_CSS: d.css = pwdata;
        OFF_CSR: d.cause_syndrome_reg = pwdata;
        OFF_FDA: d.fda = pwdata;
        // low half forced to zero keeps the base 64KB aligned
        OFF_VPR: d.vpr = {pwdata[VPR_HI:VPR_LO], 16'h0000}; // [RULE_06]
        OFF_TCR: d.timer_control_reg = pwdata; // [RULE_14]
        OFF_TSR: d.timer_status_reg = q.timer_status_reg & ~pwdata;
        OFF_MSR: d.machine_state_reg = pwdata & MSR_WMASK; // [RULE_16]
        OFF_DCA: d.dca = pwdata;
        OFF_DCB: d.dcb = pwdata;
        OFF_DST: d.dst = q.dst & ~pwdata;
        default: d.err = 1'b0;
      endcase
    end
    // hardware sets land after software clears so the set wins
    if (pit_to)  d.timer_status_reg[TSR_PIS] = 1'b1; // [RULE_11]
    if (fit_evt) d.timer_status_reg[TSR_FIS] = 1'b1; // [RULE_12]
    if (wdt_evt) d.timer_status_reg[TSR_WIS] = 1'b1; // [RULE_13]
    if (iaddr_vld && q.dca[DBG_IAC] && iaddr == q.dcb)
      d.dst[DBG_IAC] = 1'b1; // [RULE_17]
    if (daddr_vld && q.dca[DBG_DAC] && daddr == q.dcb)
      d.dst[DBG_DAC] = 1'b1; // [RULE_17]
    if (exc_itlb) d.p_itlb = 1'b1;
    if (exc_aux)  d.p_aux  = 1'b1;
    if (exc_dtlb) begin
      d.p_dtlb = 1'b1;
      d.p_st   = exc_store;
      d.fda    = exc_daddr; // [RULE_05]
    end
    // one take per two cycles leaves the core a cycle to redirect
    if (!q.take && crit_pend) begin
      d.take = 1'b1; // [RULE_20]
      d.crit = 1'b1; // [RULE_01]
      d.csa  = cur_pc; // [RULE_02]
      d.css  = q.machine_state_reg; // [RULE_02]
      d.machine_state_reg[MSR_CE] = 1'b0;
      d.machine_state_reg[MSR_EE] = 1'b0;
      d.machine_state_reg[MSR_DE] = 1'b0;
      d.machine_state_reg[MSR_WE] = 1'b0; // [RULE_18]
      if (q.machine_state_reg[MSR_CE] && crit_in)
        off = VEC_CRIT; // [RULE_07]
      else if (q.machine_state_reg[MSR_CE] && q.timer_status_reg[TSR_WIS] && q.timer_control_reg[TCR_WIE])
        off = VEC_WDT; // [RULE_08] [RULE_13]
      else
        off = VEC_DBG; // [RULE_09]
    end else if (!q.take && nc_pend) begin
      d.take = 1'b1;
      d.crit = 1'b0; // [RULE_01]
      d.nsa  = cur_pc; // [RULE_02]
      d.nss  = q.machine_state_reg; // [RULE_02]
      d.machine_state_reg[MSR_EE] = 1'b0;
      d.machine_state_reg[MSR_WE] = 1'b0; // [RULE_18]
      if (q.p_dtlb) begin
        off      = VEC_DTLB; // [RULE_09]
        // a new miss in the take cycle stays pending: the set wins
        d.p_dtlb = exc_dtlb;
        d.cause_syndrome_reg    = RST_ZERO;
        d.cause_syndrome_reg[CS_DTLB] = 1'b1; // [RULE_04]
        d.cause_syndrome_reg[CS_DST]  = q.p_st; // [RULE_04]
      end else if (q.p_itlb) begin
        off      = VEC_ITLB; // [RULE_09]
        d.p_itlb = exc_itlb;
        d.cause_syndrome_reg    = RST_ZERO;
        d.cause_syndrome_reg[CS_ITLB] = 1'b1; // [RULE_04]
      end else if (q.p_aux) begin
        off     = VEC_AUX; // [RULE_07]
        d.p_aux = exc_aux;
        d.cause_syndrome_reg   = RST_ZERO;
        d.cause_syndrome_reg[CS_AUX] = 1'b1; // [RULE_04]
      end else if (q.timer_status_reg[TSR_PIS] && q.timer_control_reg[TCR_PIE]) begin
        off = VEC_PIT; // [RULE_08]
      end else begin
        off = VEC_FIT; // [RULE_08]
      end
    end else if (cret_req) begin
      d.rvld = 1'b1;
      d.rpc  = q.csa; // [RULE_03]
      d.machine_state_reg  = q.css & MSR_WMASK; // [RULE_03]
    end else if (ret_req) begin
      d.rvld = 1'b1;
      d.rpc  = q.nsa; // [RULE_03]
      d.machine_state_reg  = q.nss & MSR_WMASK; // [RULE_03]
    end
    if (d.take)
      d.vec = {q.vpr[VPR_HI:VPR_LO], off}; // [RULE_19] [RULE_06]
    case (q.st)
      ST_RUN:  if (d.machine_state_reg[MSR_WE]) d.st = ST_WAIT; // [RULE_18]
      ST_WAIT: if (d.take || !d.machine_state_reg[MSR_WE]) d.st = ST_RUN; // [RULE_18]
      default: d.st = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q     <= '0;
      q.machine_state_reg <= RST_MSR;
      q.st  <= ST_RUN;
    end else begin
      q <= d;
    end
  end

  assign prdata      = q.rdata;
  assign pready      = q.rdy;
  assign pslverr     = q.err;
  assign acc_data    = q.acc;
  assign intr_take   = q.take;
  assign intr_crit   = q.crit;
  assign intr_vector = q.vec;
  assign resume_vld  = q.rvld;
  assign resume_pc   = q.rpc;
  assign wait_state  = (q.st == ST_WAIT);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_crit_save_pair: assert property (
    (!q.take && crit_pend) |=> intr_take && intr_crit &&
      q.csa == $past(cur_pc) && q.css == $past(q.machine_state_reg))
    else $error("critical take or save wrong"); // [RULE_02]
  chk_noncrit_save: assert property (
    (!q.take && !crit_pend && nc_pend) |=> intr_take && !intr_crit &&
      q.nsa == $past(cur_pc))
    else $error("noncritical take or save wrong"); // [RULE_02]
  chk_crit_return: assert property (
    (!q.take && !crit_pend && !nc_pend && cret_req) |=>
      resume_vld && resume_pc == $past(q.csa))
    else $error("critical return wrong"); // [RULE_03]
  chk_vector_prefix: assert property (
    intr_take |-> intr_vector[VPR_HI:VPR_LO] ==
      $past(q.vpr[VPR_HI:VPR_LO]))
    else $error("vector prefix wrong"); // [RULE_19]
  chk_wdt_critical: assert property (
    (intr_take && intr_vector[15:0] == VEC_WDT) |-> intr_crit)
    else $error("watchdog not critical"); // [RULE_13]
  chk_wait_exit: assert property (
    intr_take |-> !wait_state && !q.machine_state_reg[MSR_WE])
    else $error("wait kept after interrupt"); // [RULE_18]
  chk_endian_order: assert property (
    ##1 acc_data == ($past(acc_le) ? swap32($past(acc_wdata))
                                   : $past(acc_wdata)))
    else $error("byte order wrong"); // [RULE_15]
  chk_pit_status_set: assert property (
    pit_to |=> q.timer_status_reg[TSR_PIS])
    else $error("timeout status lost"); // [RULE_11]
  chk_dbg_fetch_hit: assert property (
    (iaddr_vld && q.dca[DBG_IAC] && iaddr == q.dcb) |=> q.dst[DBG_IAC])
    else $error("debug hit not recorded"); // [RULE_17]
  chk_dtlb_cause: assert property (
    (intr_take && intr_vector[15:0] == VEC_DTLB) |->
      q.cause_syndrome_reg[CS_DTLB] && q.p_dtlb == $past(exc_dtlb))
    else $error("cause not recorded"); // [RULE_04]

  cov_crit_take: cover property (intr_take && intr_crit);
  cov_nc_take:   cover property (intr_take && !intr_crit);
  cov_wait_wake: cover property (wait_state ##1 !wait_state);
  cov_crit_ret:  cover property (resume_vld && $past(cret_req));
endmodule // etu_unit

// ---- etu_pkg.sv ----
// constants, offsets, fields and vectors of the exception and timer unit
package etu_pkg;
  // register byte offsets on the bus
  localparam logic [11:0] OFF_NSA = 12'h000;
  localparam logic [11:0] OFF_NSS = 12'h004;
  localparam logic [11:0] OFF_CSA = 12'h008;
  localparam logic [11:0] OFF_CSS = 12'h00C;
  localparam logic [11:0] OFF_CSR = 12'h010;
  localparam logic [11:0] OFF_FDA = 12'h014;
  localparam logic [11:0] OFF_VPR = 12'h018;
  localparam logic [11:0] OFF_PIT = 12'h01C;
  localparam logic [11:0] OFF_TCR = 12'h020;
  localparam logic [11:0] OFF_TSR = 12'h024;
  localparam logic [11:0] OFF_MSR = 12'h028;
  localparam logic [11:0] OFF_DCA = 12'h02C;
  localparam logic [11:0] OFF_DCB = 12'h030;
  localparam logic [11:0] OFF_DST = 12'h034;
  localparam logic [11:0] OFF_TB  = 12'h038;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_MSR  = 32'h0000_0000;
  // machine state bits; no little-endian mode bit exists
  localparam int unsigned MSR_WE = 18;
  localparam int unsigned MSR_CE = 17;
  localparam int unsigned MSR_EE = 15;
  localparam int unsigned MSR_DE = 9;
  localparam logic [31:0] MSR_WMASK = 32'h0006_8200;
  // timer control fields
  localparam int unsigned TCR_WP  = 30;
  localparam int unsigned TCR_WIE = 27;
  localparam int unsigned TCR_PIE = 26;
  localparam int unsigned TCR_FP  = 24;
  localparam int unsigned TCR_FIE = 23;
  // timer status bits, write one to clear
  localparam int unsigned TSR_WIS = 30;
  localparam int unsigned TSR_PIS = 27;
  localparam int unsigned TSR_FIS = 26;
  // cause syndrome bits
  localparam int unsigned CS_ITLB = 31;
  localparam int unsigned CS_DTLB = 30;
  localparam int unsigned CS_AUX  = 29;
  localparam int unsigned CS_DST  = 23;
  // debug control and status bits
  localparam int unsigned DBG_IAC = 0;
  localparam int unsigned DBG_DAC = 1;
  // vector prefix field and offsets
  localparam int unsigned VPR_HI = 31;
  localparam int unsigned VPR_LO = 16;
  localparam logic [15:0] VEC_CRIT = 16'h0100;
  localparam logic [15:0] VEC_AUX  = 16'h0F20;
  localparam logic [15:0] VEC_PIT  = 16'h1000;
  localparam logic [15:0] VEC_FIT  = 16'h1010;
  localparam logic [15:0] VEC_WDT  = 16'h1020;
  localparam logic [15:0] VEC_DTLB = 16'h1100;
  localparam logic [15:0] VEC_ITLB = 16'h1200;
  localparam logic [15:0] VEC_DBG  = 16'h2000;
  // time base divider and tick taps
  localparam int unsigned TB_DIV_W = 2;
  localparam logic [TB_DIV_W-1:0] TB_DIV_LAST = 2'h3;
  localparam int unsigned FIT_TAP_BASE = 8;
  localparam int unsigned WDT_TAP_BASE = 16;
  localparam int unsigned TAP_STEP = 4;
  localparam logic [31:0] ONE32 = 32'h0000_0001;
  typedef enum logic {ST_RUN, ST_WAIT} etu_st_t;
endpackage

// ---- etu_timer.sv ----
// time base, interval countdown, fixed tick and watchdog tick detection
`timescale 1ns/10ps
module etu_timer import etu_pkg::*; (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // control
  input  wire logic [1:0]  fit_sel,
  input  wire logic [1:0]  wdt_sel,
  input  wire logic        pit_wr,
  input  wire logic [31:0] pit_wdata,
  // state and events
  output logic [31:0]      tb_val,
  output logic [31:0]      pit_val,
  output logic             pit_to,
  output logic             fit_evt,
  output logic             wdt_evt
);
  typedef struct packed {
    logic [TB_DIV_W-1:0] div;
    logic [31:0]         tb;
    logic [31:0]         interval_countdown;
    logic                pto;
    logic                fev;
    logic                wev;
  } etu_tmr_t;

  etu_tmr_t q;
  etu_tmr_t d;
  logic     tick;

  function automatic logic tap(input logic [31:0] tb,
                               input int unsigned base,
                               input logic [1:0]  sel);
    return tb[base + TAP_STEP * sel];
  endfunction

  always_comb begin
    d      = q;
    d.pto  = 1'b0;
    d.fev  = 1'b0;
    d.wev  = 1'b0;
    tick   = (q.div == TB_DIV_LAST);
    d.div  = tick ? '0 : q.div + 1'b1;
    if (tick) begin
      d.tb  = q.tb + ONE32;
      // rising edge of the selected time base bit
      d.fev = !tap(q.tb, FIT_TAP_BASE, fit_sel) &&
              tap(d.tb, FIT_TAP_BASE, fit_sel); // [RULE_12]
      d.wev = !tap(q.tb, WDT_TAP_BASE, wdt_sel) &&
              tap(d.tb, WDT_TAP_BASE, wdt_sel); // [RULE_13]
      if (q.interval_countdown != RST_ZERO) begin
        d.interval_countdown = q.interval_countdown - ONE32; // [RULE_10]
        d.pto = (q.interval_countdown == ONE32); // [RULE_11]
      end
    end
    // software load beats the tick in the same cycle
    if (pit_wr) begin
      d.interval_countdown = pit_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tb_val  = q.tb;
  assign pit_val = q.interval_countdown;
  assign pit_to  = q.pto;
  assign fit_evt = q.fev;
  assign wdt_evt = q.wev;

  chk_pit_dec_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick && q.interval_countdown > ONE32 && !pit_wr) |=> q.interval_countdown == $past(q.interval_countdown) - ONE32)
    else $error("countdown missed a tick"); // [RULE_10]
  chk_pit_to_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick && q.interval_countdown == ONE32 && !pit_wr) |=> pit_to ##1 !pit_to)
    else $error("timeout pulse wrong"); // [RULE_11]
endmodule // etu_timer

// ---- etu_src_model.sv ----
// model of the core event sources and the critical input
`timescale 1ns/10ps
module etu_src_model (
  // clock
  input  wire logic  clk_sys,
  // event sources
  output logic        crit_in,
  output logic        exc_itlb,
  output logic        exc_dtlb,
  output logic        exc_aux,
  output logic        exc_store,
  output logic [31:0] exc_daddr,
  output logic [31:0] cur_pc,
  output logic        ret_req,
  output logic        cret_req,
  output logic        iaddr_vld,
  output logic [31:0] iaddr,
  output logic        daddr_vld,
  output logic [31:0] daddr
);
  logic [8:0]  ev_q = 9'h000;
  logic [31:0] a_q = 32'h0000_0000;
  logic [31:0] pc_q = 32'h0000_0000;
  logic [31:0] lf_q = 32'h0000_0001;
  // idle address lines wander so a stale value can never match
  always @(posedge clk_sys) lf_q <= {lf_q[30:0], lf_q[31] ^ lf_q[21]};
  assign {exc_store, daddr_vld, iaddr_vld, cret_req, ret_req} = ev_q[8:4];
  assign {exc_aux, exc_dtlb, exc_itlb, crit_in} = ev_q[3:0];
  assign exc_daddr = exc_dtlb ? a_q : lf_q;
  assign iaddr = iaddr_vld ? a_q : ~lf_q;
  assign daddr = daddr_vld ? a_q : lf_q ^ 32'h5A5A_5A5A;
  assign cur_pc = pc_q;
  // one-cycle event of the chosen kinds
  task automatic fire(input logic [8:0] kinds, input logic [31:0] addr);
    @(posedge clk_sys);
    ev_q <= kinds;
    a_q <= addr;
    @(posedge clk_sys);
    ev_q <= 9'h000;
  endtask
  task automatic set_pc(input logic [31:0] pc);
    @(posedge clk_sys);
    pc_q <= pc;
  endtask
endmodule // etu_src_model

// ---- exception_timer_unit_bench.sv ----
// self-checking bench of the exception and timer unit
`timescale 1ns/10ps
module exception_timer_unit_bench;
  import etu_pkg::*;
  localparam logic [15:0] VPH = 16'hABCD;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exc_daddr, cur_pc, iaddr, daddr;
  logic        crit_in, exc_itlb, exc_dtlb, exc_aux, exc_store;
  logic        ret_req, cret_req, iaddr_vld, daddr_vld, acc_le;
  logic [31:0] acc_wdata, acc_data, intr_vector, resume_pc, rdv, r1;
  logic        intr_take, intr_crit, resume_vld, wait_state, erv;
  logic [32:0] tk_q[$];
  logic [31:0] rs_q[$];
  int          miscompares, num_checks;
  etu_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crit_in(crit_in), .exc_itlb(exc_itlb), .exc_dtlb(exc_dtlb),
    .exc_aux(exc_aux), .exc_store(exc_store), .exc_daddr(exc_daddr),
    .cur_pc(cur_pc), .ret_req(ret_req), .cret_req(cret_req),
    .iaddr_vld(iaddr_vld), .iaddr(iaddr), .daddr_vld(daddr_vld),
    .daddr(daddr), .acc_wdata(acc_wdata), .acc_le(acc_le),
    .acc_data(acc_data), .intr_take(intr_take), .intr_crit(intr_crit),
    .intr_vector(intr_vector), .resume_vld(resume_vld),
    .resume_pc(resume_pc), .wait_state(wait_state));
  etu_src_model src_u (.clk_sys(clk_sys), .crit_in(crit_in),
    .exc_itlb(exc_itlb), .exc_dtlb(exc_dtlb), .exc_aux(exc_aux),
    .exc_store(exc_store), .exc_daddr(exc_daddr), .cur_pc(cur_pc),
    .ret_req(ret_req), .cret_req(cret_req), .iaddr_vld(iaddr_vld),
    .iaddr(iaddr), .daddr_vld(daddr_vld), .daddr(daddr));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // takes and resumes are queued so back-to-back ones are never lost
  always @(posedge clk_sys) begin
    if (intr_take === 1'b1) tk_q.push_back({intr_crit, intr_vector});
    if (resume_vld === 1'b1) rs_q.push_back(resume_pc);
  end
  task automatic chk(input logic [31:0] seen, exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdv = prdata;
    erv = pslverr;
    if (pready !== 1'b1) chk(32'h0, 32'h1, "bus hang");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, e);
    apb(a, 1'b0, 32'h0);
    chk(rdv & m, e, "register");
  endtask
  task automatic take_chk(input logic [15:0] v, input logic c, input int n);
    logic [32:0] t;
    int k;
    k = 0;
    while (tk_q.size() == 0 && k < n) begin
      @(posedge clk_sys);
      k++;
    end
    if (tk_q.size() == 0) chk(32'h0, 32'h1, "no take");
    else begin
      t = tk_q.pop_front();
      chk(t[31:0], {VPH, v}, "vector");
      chk({31'h0, t[32]}, {31'h0, c}, "class");
    end
  endtask
  task automatic ret_chk(input logic [8:0] kind, input logic [31:0] pc);
    src_u.fire(kind, 32'h0);
    repeat (3) @(posedge clk_sys);
    if (rs_q.size() == 0) chk(32'h0, 32'h1, "no resume");
    else chk(rs_q.pop_front(), pc, "resume");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    miscompares++;
    test_done();
  end
  initial begin
    logic [8:0]  kd[2];
    logic [15:0] vc[2];
    int          cb[2];
    kd = '{9'h002, 9'h008};
    vc = '{VEC_ITLB, VEC_AUX};
    cb = '{CS_ITLB, CS_AUX};
    {rst_n, psel, penable, pwrite, acc_le} = 5'h00;
    {paddr, pwdata, acc_wdata} = 76'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) rdc(12'(4 * i), '1, RST_ZERO);
    apb(12'h03C, 1'b0, 32'h0);
    chk({rdv[30:0], erv}, 32'h0000_0001, "unmapped");
    $display("reset and map test done");
    wr(OFF_VPR, 32'hABCD_1234);
    rdc(OFF_VPR, '1, 32'hABCD_0000);
    wr(OFF_MSR, 32'hFFFF_FFFF);
    rdc(OFF_MSR, '1, MSR_WMASK);
    chk({31'h0, wait_state}, 32'h1, "wait");
    src_u.set_pc(32'h0000_0100);
    src_u.fire(9'h104, 32'h5555_AAA0);
    take_chk(VEC_DTLB, 1'b0, 10);
    chk({31'h0, wait_state}, 32'h0, "wake");
    rdc(OFF_FDA, '1, 32'h5555_AAA0);
    rdc(OFF_CSR, 32'h4080_0000, 32'h4080_0000);
    rdc(OFF_NSA, '1, 32'h0000_0100);
    for (int i = 0; i < 2; i++) begin
      src_u.fire(kd[i], 32'h0);
      take_chk(vc[i], 1'b0, 10);
      rdc(OFF_CSR, ONE32 << cb[i], ONE32 << cb[i]);
    end
    $display("exception test done");
    wr(OFF_MSR, 32'h0002_0000);
    src_u.set_pc(32'h0000_0200);
    src_u.fire(9'h005, 32'h1234_0000);
    take_chk(VEC_CRIT, 1'b1, 10);
    take_chk(VEC_DTLB, 1'b0, 10);
    src_u.set_pc(32'h0000_0300);
    src_u.fire(9'h004, 32'h0);
    take_chk(VEC_DTLB, 1'b0, 10);
    rdc(OFF_CSA, '1, 32'h0000_0200);
    ret_chk(9'h020, 32'h0000_0200);
    ret_chk(9'h010, 32'h0000_0300);
    $display("critical test done");
    acc_wdata <= 32'h1122_3344;
    repeat (2) @(posedge clk_sys);
    chk(acc_data, 32'h1122_3344, "big endian");
    acc_le <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(acc_data, 32'h4433_2211, "little endian");
    $display("endian test done");
    wr(OFF_PIT, 32'h0000_03E8);
    apb(OFF_PIT, 1'b0, 32'h0);
    r1 = rdv;
    repeat (37) @(posedge clk_sys);
    apb(OFF_PIT, 1'b0, 32'h0);
    chk(r1 - rdv, 32'h0000_000A, "count rate");
    wr(OFF_MSR, ONE32 << MSR_EE);
    wr(OFF_TCR, ONE32 << TCR_PIE);
    wr(OFF_PIT, 32'h0000_0003);
    take_chk(VEC_PIT, 1'b0, 100);
    rdc(OFF_TSR, ONE32 << TSR_PIS, ONE32 << TSR_PIS);
    wr(OFF_TSR, ONE32 << TSR_PIS);
    rdc(OFF_TSR, ONE32 << TSR_PIS, 32'h0);
    wr(OFF_MSR, ONE32 << MSR_EE);
    wr(OFF_TCR, ONE32 << TCR_FIE);
    take_chk(VEC_FIT, 1'b0, 2200);
    wr(OFF_TCR, 32'h0);
    $display("timer test done");
    wr(OFF_DCB, 32'h0000_4000);
    wr(OFF_DCA, ONE32 << DBG_IAC);
    wr(OFF_MSR, ONE32 << MSR_DE);
    src_u.fire(9'h040, 32'h0000_4000);
    take_chk(VEC_DBG, 1'b1, 10);
    rdc(OFF_DST, 32'h1, 32'h1);
    wr(OFF_DST, 32'h3);
    wr(OFF_DCA, ONE32 << DBG_DAC);
    src_u.fire(9'h080, 32'h0000_4000);
    repeat (3) @(posedge clk_sys);
    rdc(OFF_DST, 32'h3, 32'h2);
    $display("debug test done");
    test_done();
  end
endmodule // exception_timer_unit_bench
